// >>> rtl/laser_fault_map.svh
// Register offsets, field positions, reset values and timing for the fault monitor.
`ifndef LASER_FAULT_MAP_SVH
`define LASER_FAULT_MAP_SVH
`define REG_MONITOR_CFG     8'h0a
`define REG_BIAS_LEVEL      8'h0b
`define REG_PHOTO_LEVEL     8'h0c
`define REG_CONV_CTRL       8'h0d
`define REG_CONV_RES_HI     8'h0e
`define REG_CONV_RES_LO     8'h0f
`define BIT_DIG_BIAS_SEL    0
`define BIT_DIG_PHOTO_SEL   1
`define BIT_PHOTO_TRIGGER   2
`define BIT_CONV_OSC_OFF    6
`define BIT_CONV_OFF        7
`define RST_REG_VALUE       8'h00
`define LATCH_RESET_NS      100
`define NEGATE_NS           200
`define CLK_PERIOD_NS       25
`define LATCH_RESET_CYC     ((`LATCH_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NEGATE_CYC          ((`NEGATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> rtl/laser_fault_pkg.sv
// Types shared by the laser fault monitor.
package laser_fault_pkg;
  typedef enum logic [1:0] {
    SRC_TEMP,
    SRC_SUPPLY,
    SRC_PHOTO,
    SRC_BIAS
  } conv_src_t;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_FAULT,
    ST_CLEAR,
    ST_NEGATE
  } fault_state_t;
endpackage : laser_fault_pkg

// >>> rtl/fault_detect.sv
// Combines the per-cycle fault sources into one registered fault flag.
`timescale 1ns/100ps
module fault_detect
  import laser_fault_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         dig_bias_sel_i,
  input  wire logic         dig_photo_sel_i,
  input  wire logic         photo_trigger_i,
  input  wire logic         bias_above_ref_i,
  input  wire logic         photo_above_ref_i,
  input  wire logic [W-1:0] bias_level_i,
  input  wire logic [W-1:0] photo_level_i,
  input  wire logic [W-1:0] bias_code_i,
  input  wire logic [W-1:0] photo_code_i,
  input  wire logic [W-1:0] photo_set_i,
  input  wire logic [W-1:0] bias_dac_i,
  output logic              fault_o
);
  logic [W-1:0] dac_prev_q;
  logic         bias_f;
  logic         photo_f;
  logic         over_f;
  logic         drop_f;

  // Bias fault from the pin comparator or from the digital threshold.
  assign bias_f  = dig_bias_sel_i ? (bias_code_i > bias_level_i)
                                  : bias_above_ref_i;
  // The analog photo comparator counts only when its trigger bit is set.
  assign photo_f = dig_photo_sel_i ? (photo_code_i > photo_level_i)
                                   : (photo_above_ref_i
                                      && photo_trigger_i);
  // Above 150 percent: 2*code > 3*set, widened to avoid overflow.
  assign over_f  = ({1'b0, photo_code_i, 1'b0}
                    > ({2'b00, photo_set_i} + {1'b0, photo_set_i, 1'b0}));
  // A drop of more than half: 2*(prev - new) > prev.
  assign drop_f  = (bias_dac_i < dac_prev_q)
                   && ({1'b0, dac_prev_q - bias_dac_i, 1'b0}
                       > {2'b00, dac_prev_q});

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dac_prev_q <= '0;
    end else begin
      dac_prev_q <= bias_dac_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= bias_f || photo_f || over_f || drop_f;
    end
  end

  AST_DROP_FLAGS: assert property (
    @(posedge clk_i) disable iff (reset_i)
    drop_f |=> fault_o)
    else $error("DAC drop did not raise fault");
  AST_OVER_FLAGS: assert property (
    @(posedge clk_i) disable iff (reset_i)
    over_f |=> fault_o)
    else $error("Photo overcurrent did not raise fault");
  AST_PHOTO_MASK: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!dig_photo_sel_i && !photo_trigger_i && !bias_f && !over_f && !drop_f)
    |=> !fault_o)
    else $error("Masked analog photo input raised fault");
endmodule : fault_detect

// >>> rtl/laser_fault_monitor_adc_regs.sv
// Laser driver fault supervisor with monitor and converter registers.
`timescale 1ns/100ps
`include "laser_fault_map.svh"
module laser_fault_monitor_adc_regs
#(
  parameter int W            = 8,
  parameter int LATCH_CYCLES = `LATCH_RESET_CYC,
  parameter int NEGATE_CYCLES = `NEGATE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        disable_in_i,
  input  wire logic        internal_on_bit_i,
  input  wire logic        fault_latch_allow_i,
  input  wire logic        bias_above_ref_i,
  input  wire logic        photo_above_ref_i,
  input  wire logic [W-1:0] bias_code_i,
  input  wire logic [W-1:0] photo_code_i,
  input  wire logic [W-1:0] photo_set_i,
  input  wire logic [W-1:0] bias_dac_i,
  input  wire logic [W-1:0] mod_dac_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_value_i,
  output logic [W-1:0]     bias_out_o,
  output logic [W-1:0]     mod_out_o,
  output logic             fault_out_o,
  output logic             converter_off_o,
  output logic             converter_osc_off_o,
  output laser_fault_pkg::conv_src_t converter_input_sel_o
);
  import laser_fault_pkg::*;

  logic [2:0]   monitor_cfg_q;
  logic [W-1:0] bias_fault_level_q;
  logic [W-1:0] photo_fault_level_q;
  logic [7:0]   conv_ctrl_q;
  logic [9:0]   conv_result_q;
  fault_state_t state_q;
  logic [15:0]  count_q;
  logic         fault_now;
  logic         off_req;

  function automatic logic [7:0] pad8(input logic [W-1:0] v);
    pad8 = 8'(v);
  endfunction : pad8

  fault_detect #(
    .W (W)
  ) u_detect (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .dig_bias_sel_i    (monitor_cfg_q[`BIT_DIG_BIAS_SEL]),
    .dig_photo_sel_i   (monitor_cfg_q[`BIT_DIG_PHOTO_SEL]),
    .photo_trigger_i   (monitor_cfg_q[`BIT_PHOTO_TRIGGER]),
    .bias_above_ref_i  (bias_above_ref_i),
    .photo_above_ref_i (photo_above_ref_i),
    .bias_level_i      (bias_fault_level_q),
    .photo_level_i     (photo_fault_level_q),
    .bias_code_i       (bias_code_i),
    .photo_code_i      (photo_code_i),
    .photo_set_i       (photo_set_i),
    .bias_dac_i        (bias_dac_i),
    .fault_o           (fault_now)
  );

  // Register writes; result registers ignore writes.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      monitor_cfg_q       <= 3'h0;
      bias_fault_level_q  <= '0;
      photo_fault_level_q <= '0;
      conv_ctrl_q         <= `RST_REG_VALUE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `REG_MONITOR_CFG) begin
        monitor_cfg_q <= reg_wdata_i[2:0];
      end else if (reg_addr_i == `REG_BIAS_LEVEL) begin
        bias_fault_level_q <= reg_wdata_i[W-1:0];
      end else if (reg_addr_i == `REG_PHOTO_LEVEL) begin
        photo_fault_level_q <= reg_wdata_i[W-1:0];
      end else if (reg_addr_i == `REG_CONV_CTRL) begin
        conv_ctrl_q <= {reg_wdata_i[7:6], 4'h0, reg_wdata_i[1:0]};
      end
    end
  end

  // Conversions are accepted only while the converter is running.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      conv_result_q <= 10'h000;
    end else if (conv_done_i && !conv_ctrl_q[`BIT_CONV_OFF]
                 && !conv_ctrl_q[`BIT_CONV_OSC_OFF]) begin
      conv_result_q <= conv_value_i;
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `REG_MONITOR_CFG) begin
        reg_rdata_o <= {5'h00, monitor_cfg_q};
      end else if (reg_addr_i == `REG_BIAS_LEVEL) begin
        reg_rdata_o <= pad8(bias_fault_level_q);
      end else if (reg_addr_i == `REG_PHOTO_LEVEL) begin
        reg_rdata_o <= pad8(photo_fault_level_q);
      end else if (reg_addr_i == `REG_CONV_CTRL) begin
        reg_rdata_o <= conv_ctrl_q;
      end else if (reg_addr_i == `REG_CONV_RES_HI) begin
        reg_rdata_o <= conv_result_q[9:2];
      end else if (reg_addr_i == `REG_CONV_RES_LO) begin
        reg_rdata_o <= {6'h00, conv_result_q[1:0]};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // Converter control outputs follow the control register.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      converter_off_o       <= 1'b0;
      converter_osc_off_o   <= 1'b0;
      converter_input_sel_o <= SRC_TEMP;
    end else begin
      converter_off_o       <= conv_ctrl_q[`BIT_CONV_OFF];
      converter_osc_off_o   <= conv_ctrl_q[`BIT_CONV_OSC_OFF];
      converter_input_sel_o <= conv_src_t'(conv_ctrl_q[1:0]);
    end
  end

  assign off_req = disable_in_i || !internal_on_bit_i;

  // Recovery: the off request must hold for the latch reset time before
  // the latch clears, then outputs wait the negate time before returning.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ST_RUN;
      count_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_RUN: begin
          count_q <= 16'h0000;
          if (fault_now && fault_latch_allow_i) begin
            state_q <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (off_req) begin
            if (count_q >= 16'(LATCH_CYCLES - 1)) begin
              state_q <= ST_CLEAR;
              count_q <= 16'h0000;
            end else begin
              count_q <= count_q + 16'h0001;
            end
          end else begin
            count_q <= 16'h0000;
          end
        end
        ST_CLEAR: begin
          count_q <= 16'h0000;
          if (!off_req) begin
            if (fault_now && fault_latch_allow_i) begin
              state_q <= ST_FAULT;
            end else begin
              state_q <= ST_NEGATE;
            end
          end
        end
        ST_NEGATE: begin
          if (off_req) begin
            state_q <= ST_CLEAR;
            count_q <= 16'h0000;
          end else if (fault_now && fault_latch_allow_i) begin
            state_q <= ST_FAULT;
            count_q <= 16'h0000;
          end else if (count_q >= 16'(NEGATE_CYCLES - 1)) begin
            state_q <= ST_RUN;
            count_q <= 16'h0000;
          end else begin
            count_q <= count_q + 16'h0001;
          end
        end
        default: begin
          state_q <= ST_RUN;
          count_q <= 16'h0000;
        end
      endcase
    end
  end

  // Currents are zero while faulted, cleared or negating; the DAC
  // settings themselves are untouched, so the old values come back.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bias_out_o <= '0;
      mod_out_o  <= '0;
    end else if (state_q == ST_RUN && !off_req
                 && !(fault_now && fault_latch_allow_i)) begin
      bias_out_o <= bias_dac_i;
      mod_out_o  <= mod_dac_i;
    end else begin
      bias_out_o <= '0;
      mod_out_o  <= '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_out_o <= 1'b0;
    end else begin
      fault_out_o <= (state_q == ST_FAULT);
    end
  end

  // The latch may only be left once the off request has run its full time.
  AST_FAULT_ZEROES: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_RUN && fault_now && fault_latch_allow_i)
    |=> (bias_out_o == '0 && mod_out_o == '0) ##1 fault_out_o)
    else $error("Fault did not zero outputs then latch");
  AST_FAULT_HOLDS: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_FAULT && !off_req) |=> fault_out_o)
    else $error("Fault output dropped without recovery");
  AST_CLEAR_DROPS: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_CLEAR) |=> !fault_out_o)
    else $error("Fault output high while cleared");
  AST_REASSERT: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_CLEAR && !off_req && fault_now && fault_latch_allow_i)
    |=> ##1 fault_out_o)
    else $error("Persisting fault not reasserted");
  AST_RESUME: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_NEGATE && count_q >= 16'(NEGATE_CYCLES - 1)
     && !off_req && !(fault_now && fault_latch_allow_i))
    |=> state_q == ST_RUN)
    else $error("No resume after negate time");
  AST_RES_LOW: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_rd_i && reg_addr_i == `REG_CONV_RES_LO)
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("Unused result bits not zero");
  AST_CONV_OFF: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_CONV_CTRL)
    |=> ##1 converter_off_o == $past(reg_wdata_i[7], 2))
    else $error("Converter off bit not applied");
  AST_SEL: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_CONV_CTRL)
    |=> ##1 converter_input_sel_o == $past(reg_wdata_i[1:0], 2))
    else $error("Input select not applied");
  AST_BIAS_LEVEL_WR: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_BIAS_LEVEL)
    |=> bias_fault_level_q == $past(reg_wdata_i[W-1:0]))
    else $error("Bias threshold write lost");
  AST_PHOTO_LEVEL_WR: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_PHOTO_LEVEL)
    |=> photo_fault_level_q == $past(reg_wdata_i[W-1:0]))
    else $error("Photo threshold write lost");
  AST_CFG_WR: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_MONITOR_CFG)
    |=> monitor_cfg_q == $past(reg_wdata_i[2:0]))
    else $error("Monitor select write lost");
  AST_CTRL_RSVD: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_CONV_CTRL) |=> conv_ctrl_q[5:2] == 4'h0)
    else $error("Unused control bits stored");
  AST_OSC_OFF: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `REG_CONV_CTRL)
    |=> ##1 converter_osc_off_o == $past(reg_wdata_i[6], 2))
    else $error("Oscillator off bit not applied");
  AST_CONV_GATED: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (conv_ctrl_q[`BIT_CONV_OFF] || conv_ctrl_q[`BIT_CONV_OSC_OFF])
    |=> $stable(conv_result_q))
    else $error("Result changed while converter off");
  AST_RES_HI: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (reg_rd_i && reg_addr_i == `REG_CONV_RES_HI)
    |=> reg_rdata_o == $past(conv_result_q[9:2]))
    else $error("Result high bits misread");
  AST_RES_RO: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !conv_done_i |=> $stable(conv_result_q))
    else $error("Result changed without conversion");
  AST_BIAS_DIGITAL: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (monitor_cfg_q[`BIT_DIG_BIAS_SEL] && bias_code_i > bias_fault_level_q)
    |=> fault_now)
    else $error("Digital bias fault missed");
  AST_BIAS_ANALOG: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!monitor_cfg_q[`BIT_DIG_BIAS_SEL] && bias_above_ref_i) |=> fault_now)
    else $error("Analog bias fault missed");
  AST_PHOTO_DIGITAL: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (monitor_cfg_q[`BIT_DIG_PHOTO_SEL] && photo_code_i > photo_fault_level_q)
    |=> fault_now)
    else $error("Digital photo fault missed");
  AST_PHOTO_ANALOG: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (!monitor_cfg_q[`BIT_DIG_PHOTO_SEL] && monitor_cfg_q[`BIT_PHOTO_TRIGGER]
     && photo_above_ref_i) |=> fault_now)
    else $error("Analog photo fault missed");
  AST_RUN_QUIET: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_RUN && !fault_latch_allow_i) |=> state_q == ST_RUN)
    else $error("Fault latched while fault handling off");
  AST_LATCH_WAIT: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_FAULT && count_q < 16'(LATCH_CYCLES - 1))
    |=> state_q == ST_FAULT)
    else $error("Latch cleared before reset time");
  AST_CLEAR_WHILE_OFF: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_CLEAR && off_req) |=> state_q == ST_CLEAR)
    else $error("Cleared state left while still off");
  AST_NEGATE_ZERO: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_NEGATE) |=> (bias_out_o == '0 && mod_out_o == '0))
    else $error("Currents on during negate time");
  AST_RUN_FOLLOWS: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_RUN && !off_req && !(fault_now && fault_latch_allow_i))
    |=> (bias_out_o == $past(bias_dac_i) && mod_out_o == $past(mod_dac_i)))
    else $error("Currents do not follow settings");
  AST_NEGATE_REFAULT: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == ST_NEGATE && !off_req && fault_now && fault_latch_allow_i)
    |=> state_q == ST_FAULT)
    else $error("Fault during negate time not latched");
endmodule : laser_fault_monitor_adc_regs

// >>> bench/host_model.sv
// Host controller model driving the register strobes and the disable pin.
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            disable_in_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'h00;
    disable_in_o = 1'b0;
  end
  // Address is inverted once a transfer ends, and write data once a write
  // ends, so stale values cannot mask a decode fault.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    #1 d = reg_rdata_i;
  endtask : rd
  task automatic hold_disable(input logic level);
    @(posedge clk_i);
    disable_in_o <= level;
  endtask : hold_disable
endmodule : host_model

// >>> bench/testbench.sv
// Self-checking bench for the laser fault monitor and converter registers.
`timescale 1ns/100ps
`include "laser_fault_map.svh"
module testbench;
  import laser_fault_pkg::*;
  localparam int LC = 4;
  localparam int NC = 8;
  logic clk_i, reset_i, reg_wr, reg_rd, dis, on_bit, allow, conv_done;
  logic bias_ref, photo_ref, c_off, c_osc, fault;
  logic [7:0] addr, wdata, rdata, b_code, p_code, p_set, b_dac, m_dac;
  logic [7:0] b_out, m_out;
  logic [9:0] conv_val;
  conv_src_t sel;
  int mismatches;
  int check_count;
  laser_fault_monitor_adc_regs #(.LATCH_CYCLES(LC), .NEGATE_CYCLES(NC))
    i_laser_fault_monitor_adc_regs (.clk_i(clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .disable_in_i(dis),
    .internal_on_bit_i(on_bit), .fault_latch_allow_i(allow),
    .bias_above_ref_i(bias_ref), .photo_above_ref_i(photo_ref),
    .bias_code_i(b_code), .photo_code_i(p_code), .photo_set_i(p_set),
    .bias_dac_i(b_dac), .mod_dac_i(m_dac), .conv_done_i(conv_done),
    .conv_value_i(conv_val), .bias_out_o(b_out), .mod_out_o(m_out),
    .fault_out_o(fault), .converter_off_o(c_off),
    .converter_osc_off_o(c_osc), .converter_input_sel_o(sel));
  host_model i_host_model (.clk_i(clk_i), .reg_rdata_i(rdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .disable_in_o(dis));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_model.rd(a, d);
    check("rdata", {2'b00, d}, {2'b00, exp});
  endtask : rd_check
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic expect_fault(input logic exp);
    settle(6);
    check("fault", fault, exp);
    if (exp) begin
      check("bias", b_out, 10'h000);
      check("mod", m_out, 10'h000);
    end
    @(posedge clk_i);
  endtask : expect_fault
  // Recovery through the pin or the enable bit; the hold exceeds LC.
  task automatic recover(input logic use_bit, input logic persist);
    if (use_bit) @(posedge clk_i) on_bit <= 1'b0;
    else i_host_model.hold_disable(1'b1);
    settle(LC + 2);
    check("fault", fault, 1'b0);
    if (use_bit) @(posedge clk_i) on_bit <= 1'b1;
    else i_host_model.hold_disable(1'b0);
    settle(persist ? 5 : NC + 4);
    check("fault", fault, persist);
    if (!persist) check("bias", b_out, b_dac);
    if (!persist) check("mod", m_out, m_dac);
    @(posedge clk_i);
  endtask : recover
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end
  initial begin
    mismatches = 0;
    check_count = 0;
    reset_i = 1'b1;
    {on_bit, allow, bias_ref, photo_ref, conv_done} = 5'b10000;
    {b_code, p_code, p_set, b_dac, m_dac} = 40'h00_10_80_80_55;
    conv_val = 10'h000;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 8'h0a; a <= 8'h10; a++) rd_check(8'(a), `RST_REG_VALUE);
    end_test("reset");
    i_host_model.wr(`REG_BIAS_LEVEL, 8'ha5);
    rd_check(`REG_BIAS_LEVEL, 8'ha5);
    i_host_model.wr(`REG_PHOTO_LEVEL, 8'h5a);
    rd_check(`REG_PHOTO_LEVEL, 8'h5a);
    for (int s = 0; s < 4; s++) begin
      i_host_model.wr(`REG_CONV_CTRL, {6'h3f, 2'(s)});
      settle(3);
      check("off", {c_osc, c_off}, 2'b11);
      check("sel", sel, 10'(s));
      rd_check(`REG_CONV_CTRL, {6'h30, 2'(s)});
    end
    i_host_model.wr(`REG_CONV_CTRL, 8'h40);
    settle(3);
    check("off", {c_osc, c_off}, 2'b10);
    i_host_model.wr(`REG_CONV_CTRL, 8'h00);
    @(posedge clk_i) {conv_done, conv_val} <= {1'b1, 10'h2b5};
    @(posedge clk_i) conv_done <= 1'b0;
    rd_check(`REG_CONV_RES_HI, 8'had);
    rd_check(`REG_CONV_RES_LO, 8'h01);
    i_host_model.wr(`REG_CONV_RES_HI, 8'hff);
    rd_check(`REG_CONV_RES_HI, 8'had);
    end_test("registers");
    @(posedge clk_i) allow <= 1'b1;
    i_host_model.wr(`REG_MONITOR_CFG, 8'h01);
    i_host_model.wr(`REG_BIAS_LEVEL, 8'h40);
    {bias_ref, b_code} <= 9'h140;
    expect_fault(1'b0);
    {bias_ref, b_code} <= 9'h041;
    expect_fault(1'b1);
    recover(1'b0, 1'b1);
    b_code <= 8'h00;
    recover(1'b1, 1'b0);
    end_test("digital bias");
    i_host_model.wr(`REG_MONITOR_CFG, 8'h00);
    bias_ref <= 1'b1;
    expect_fault(1'b1);
    bias_ref <= 1'b0;
    recover(1'b0, 1'b0);
    photo_ref <= 1'b1;
    expect_fault(1'b0);
    i_host_model.wr(`REG_MONITOR_CFG, 8'h04);
    expect_fault(1'b1);
    photo_ref <= 1'b0;
    recover(1'b0, 1'b0);
    end_test("analog");
    i_host_model.wr(`REG_MONITOR_CFG, 8'h02);
    i_host_model.wr(`REG_PHOTO_LEVEL, 8'h30);
    p_code <= 8'h30;
    expect_fault(1'b0);
    p_code <= 8'h31;
    expect_fault(1'b1);
    p_code <= 8'h10;
    recover(1'b0, 1'b0);
    i_host_model.wr(`REG_MONITOR_CFG, 8'h00);
    {p_set, p_code} <= 16'h20_30;
    expect_fault(1'b0);
    p_code <= 8'h31;
    expect_fault(1'b1);
    p_code <= 8'h10;
    recover(1'b0, 1'b0);
    end_test("photo");
    b_dac <= 8'h40;
    expect_fault(1'b0);
    b_dac <= 8'h80;
    expect_fault(1'b0);
    b_dac <= 8'h3f;
    expect_fault(1'b1);
    recover(1'b0, 1'b0);
    allow <= 1'b0;
    bias_ref <= 1'b1;
    expect_fault(1'b0);
    check("bias", b_out, b_dac);
    end_test("dac step and enable");
    print_verdict();
  end
endmodule : testbench
